// ### rtr_regs.sv
// receiver trim and signal level register bank behind an ahb-lite slave port
//
// Overview of operation
// - coarse crystal trim code maps linearly, 1 pF per step, 00h..18h
// - coarse codes above 18h saturate to the 24 pF setting
// - fine trim bits 3,2,1 connect 500, 250, 125 fF capacitors independently
// - level monitor buffer enable follows bit 0, set out of reset
// - converter input: 000 level, 001 temperature, 010 half supply, rest unused
// - offset code means -256 at 00h to 254 at FFh, steps of two
// - level multiplied by slope code times 2^-7; 80h gives unity
// - positive rate threshold only checked while rate limit enable is set
`timescale 1ns/1ns
module rtr_regs
  import rtr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [RTR_ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [RTR_DATA_W-1:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [RTR_DATA_W-1:0] hrdata,
  output logic hresp,
  input wire logic [7:0] level_sample,
  input wire logic [7:0] rate_dev_pos,
  output logic [4:0] crystal_coarse_cap_code,
  output logic crystal_fine_cap_500ff,
  output logic crystal_fine_cap_250ff,
  output logic crystal_fine_cap_125ff,
  output logic crystal_fine_cap_lsb,
  output logic level_monitor_buffer_enable,
  output logic [2:0] converter_input_code,
  output logic conv_sel_level,
  output logic conv_sel_temp,
  output logic conv_sel_half_supply,
  output logic [8:0] level_offset_value,
  output logic [10:0] level_compensated,
  output logic rate_accept
);
  typedef struct packed {
    rtr_bus_t bus;
    logic [7:0] idx;
    logic [4:0] coarse;
    logic [3:0] fine;
    logic mon_en;
    logic [2:0] conv;
    logic [7:0] offset;
    logic [7:0] slope;
    logic [7:0] thr;
    logic limit_en;
    logic sel_level;
    logic sel_temp;
    logic sel_half;
    logic accept;
    logic [RTR_DATA_W-1:0] rdata;
    logic ready;
    logic resp;
  } rtr_state_t;

  localparam rtr_state_t RTR_STATE_RST = '{
    bus: RTR_BUS_IDLE,
    idx: RTR_IDX_NONE,
    coarse: RTR_RST_COARSE,
    fine: RTR_RST_FINE,
    mon_en: RTR_RST_MON_EN,
    conv: RTR_RST_CONVERTER,
    offset: RTR_RST_OFFSET,
    slope: RTR_RST_SLOPE,
    thr: RTR_RST_POS_THR,
    limit_en: RTR_RST_LIMIT_EN,
    sel_level: 1'b1,
    sel_temp: 1'b0,
    sel_half: 1'b0,
    accept: 1'b1,
    rdata: '0,
    ready: 1'b1,
    resp: 1'b0
  };

  rtr_state_t q;
  rtr_state_t next_q;
  rtr_cfg_if cfg ();

  // word index of a byte address; misaligned or out of window is unmapped
  function automatic logic [7:0] rtr_index(input logic [RTR_ADDR_W-1:0] addr);
    if (addr[1:0] != 2'b00 || addr[RTR_ADDR_W-1:10] != '0) begin
      return RTR_IDX_NONE;
    end
    return addr[9:2];
  endfunction : rtr_index

  // converter select decode, applied to the next converter code each cycle; reset loads the level select directly
  function automatic logic [2:0] rtr_conv_onehot(input logic [2:0] code);
    unique case (code)
      RTR_CONV_LEVEL: return 3'h1;
      RTR_CONV_TEMP: return 3'h2;
      RTR_CONV_HALF_SUPPLY: return 3'h4;
      default: return 3'h0;
    endcase
  endfunction : rtr_conv_onehot

  logic accept_addr;
  logic [RTR_DATA_W-1:0] read_word;
  logic [2:0] conv_sel;

  assign accept_addr = hsel && htrans[1] && hready;

  always_comb begin
    read_word = '0;
    unique case (q.idx)
      RTR_IDX_COARSE: read_word[RTR_COARSE_W-1:0] = q.coarse;
      RTR_IDX_FINE: read_word[RTR_FINE_W-1:0] = q.fine;
      RTR_IDX_MONITOR: read_word[RTR_MON_EN_BIT] = q.mon_en;
      RTR_IDX_CONVERTER: read_word[RTR_CONV_W-1:0] = q.conv;
      RTR_IDX_OFFSET: read_word[7:0] = q.offset;
      RTR_IDX_SLOPE: read_word[7:0] = q.slope;
      RTR_IDX_POS_THR: read_word[7:0] = q.thr;
      RTR_IDX_CONTROL: read_word[RTR_LIMIT_EN_BIT] = q.limit_en;
      RTR_IDX_STATUS: begin
        read_word[RTR_STAT_COARSE_LSB +: 5] = cfg.coarse_applied;
        read_word[RTR_STAT_FINE_LSB +: 3] = cfg.fine_eighths;
        read_word[RTR_STAT_ACCEPT_BIT] = q.accept;
      end
      default: read_word = '0;
    endcase
  end

  always_comb begin
    next_q = q;
    conv_sel = 3'h0;
    next_q.resp = 1'b0;
    unique case (q.bus)
      RTR_BUS_IDLE, RTR_BUS_WRITE: begin
        if (q.bus == RTR_BUS_WRITE) begin
          // only the defined field bits are stored
          unique case (q.idx)
            RTR_IDX_COARSE: next_q.coarse = hwdata[RTR_COARSE_W-1:0];
            RTR_IDX_FINE: next_q.fine = hwdata[RTR_FINE_W-1:0];
            RTR_IDX_MONITOR: next_q.mon_en = hwdata[RTR_MON_EN_BIT];
            RTR_IDX_CONVERTER: next_q.conv = hwdata[RTR_CONV_W-1:0];
            RTR_IDX_OFFSET: next_q.offset = hwdata[7:0];
            RTR_IDX_SLOPE: next_q.slope = hwdata[7:0];
            RTR_IDX_POS_THR: next_q.thr = hwdata[7:0];
            RTR_IDX_CONTROL: next_q.limit_en = hwdata[RTR_LIMIT_EN_BIT];
            default: next_q.idx = q.idx;
          endcase
        end
        if (accept_addr) begin
          next_q.idx = rtr_index(haddr);
          if (hwrite) begin
            next_q.bus = RTR_BUS_WRITE;
          end else begin
            // one wait state lets a write just before be seen by this read
            next_q.bus = RTR_BUS_READ;
            next_q.ready = 1'b0;
          end
        end else begin
          next_q.bus = RTR_BUS_IDLE;
        end
      end
      RTR_BUS_READ: begin
        next_q.rdata = read_word;
        next_q.ready = 1'b1;
        next_q.bus = RTR_BUS_IDLE;
      end
      default: next_q.bus = RTR_BUS_IDLE;
    endcase
    conv_sel = rtr_conv_onehot(next_q.conv);
    next_q.sel_level = conv_sel[0];
    next_q.sel_temp = conv_sel[1];
    next_q.sel_half = conv_sel[2];
    // without the enable every positive deviation is tolerated
    next_q.accept = !q.limit_en || (rate_dev_pos <= q.thr);
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      q <= RTR_STATE_RST;
    end else begin
      q <= next_q;
    end
  end

  assign cfg.coarse_code = q.coarse;
  assign cfg.fine_bits = q.fine;
  assign cfg.level_in = level_sample;
  assign cfg.slope = q.slope;
  assign cfg.offset = q.offset;

  rtr_trim_decode u_trim (
    .ref_clk(ref_clk),
    .reset(reset),
    .cfg(cfg.trim)
  );

  rtr_level_comp u_comp (
    .ref_clk(ref_clk),
    .reset(reset),
    .cfg(cfg.comp)
  );

  assign hreadyout = q.ready;
  assign hrdata = q.rdata;
  assign hresp = q.resp;
  assign crystal_coarse_cap_code = cfg.coarse_applied;
  assign crystal_fine_cap_500ff = q.fine[3];
  assign crystal_fine_cap_250ff = q.fine[2];
  assign crystal_fine_cap_125ff = q.fine[1];
  assign crystal_fine_cap_lsb = q.fine[0];
  assign level_monitor_buffer_enable = q.mon_en;
  assign converter_input_code = q.conv;
  assign conv_sel_level = q.sel_level;
  assign conv_sel_temp = q.sel_temp;
  assign conv_sel_half_supply = q.sel_half;
  assign level_offset_value = cfg.offset_value;
  assign level_compensated = cfg.level_comp;
  assign rate_accept = q.accept;

  default clocking rtr_cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  coarse_linear_a: assert property (
    (q.coarse <= RTR_COARSE_MAX) |=> crystal_coarse_cap_code == $past(q.coarse))
    else $error("coarse trim not passed through linearly");

  coarse_clamp_a: assert property (
    (q.coarse > RTR_COARSE_MAX) |=> crystal_coarse_cap_code == 5'h18)
    else $error("coarse trim above top code not clamped");

  fine_weight_a: assert property (
    ##1 cfg.fine_eighths == {$past(crystal_fine_cap_500ff),
      $past(crystal_fine_cap_250ff), $past(crystal_fine_cap_125ff)})
    else $error("fine trim weights wrong");

  monitor_write_a: assert property (
    (q.bus == RTR_BUS_WRITE && q.idx == RTR_IDX_MONITOR)
    |=> level_monitor_buffer_enable == $past(hwdata[0]))
    else $error("monitor buffer enable not written");

  conv_select_a: assert property (
    (converter_input_code == 3'h1 |-> conv_sel_temp && !conv_sel_level)
    and (converter_input_code > 3'h2 |-> !(conv_sel_level || conv_sel_temp
      || conv_sel_half_supply)))
    else $error("converter select decode wrong");

  offset_scale_a: assert property (
    ##1 $signed(level_offset_value) == 2 * $signed({1'b0, $past(q.offset)}) - 256)
    else $error("offset code scaling wrong");

  slope_unity_a: assert property (
    (q.slope == 8'h80 && q.offset == 8'h80) |=> level_compensated
    == {3'b000, $past(level_sample)})
    else $error("unity slope did not pass level through");

  rate_gate_a: assert property (
    (!q.limit_en |=> rate_accept)
    and ((q.limit_en && rate_dev_pos > q.thr) |=> !rate_accept))
    else $error("rate threshold gating wrong");

  unused_zero_a: assert property (
    (q.bus == RTR_BUS_READ && q.idx == RTR_IDX_COARSE) |=> hrdata[31:5] == '0)
    else $error("unused coarse bits read nonzero");

  read_wait_a: assert property (
    (accept_addr && !hwrite) |=> !hreadyout ##1 hreadyout)
    else $error("read wait state sequence wrong");

  write_no_wait_a: assert property (
    (accept_addr && hwrite) |=> hreadyout && q.bus == RTR_BUS_WRITE)
    else $error("write data phase did not start without wait");

  read_no_take_a: assert property (
    (q.bus == RTR_BUS_READ) |=> hreadyout && q.bus == RTR_BUS_IDLE)
    else $error("read wait cycle took a new address phase");

  coarse_store_a: assert property (
    (q.bus == RTR_BUS_WRITE && q.idx == RTR_IDX_COARSE)
    |=> q.coarse == $past(hwdata[RTR_COARSE_W-1:0]))
    else $error("coarse trim field not stored");

  fine_store_a: assert property (
    (q.bus == RTR_BUS_WRITE && q.idx == RTR_IDX_FINE)
    |=> {crystal_fine_cap_500ff, crystal_fine_cap_250ff, crystal_fine_cap_125ff,
      crystal_fine_cap_lsb} == $past(hwdata[RTR_FINE_W-1:0]))
    else $error("fine trim switches not written");

  conv_store_a: assert property (
    (q.bus == RTR_BUS_WRITE && q.idx == RTR_IDX_CONVERTER)
    |=> converter_input_code == $past(hwdata[RTR_CONV_W-1:0]))
    else $error("converter select code not written");

  offset_store_a: assert property (
    (q.bus == RTR_BUS_WRITE && q.idx == RTR_IDX_OFFSET)
    |=> q.offset == $past(hwdata[7:0]))
    else $error("offset code not written");

  slope_store_a: assert property (
    (q.bus == RTR_BUS_WRITE && q.idx == RTR_IDX_SLOPE)
    |=> q.slope == $past(hwdata[7:0]))
    else $error("slope code not written");

  thr_store_a: assert property (
    (q.bus == RTR_BUS_WRITE && q.idx == RTR_IDX_POS_THR)
    |=> q.thr == $past(hwdata[7:0]))
    else $error("positive rate threshold not written");

  // unmapped and misaligned writes must leave every field alone
  config_hold_a: assert property (
    (q.bus != RTR_BUS_WRITE || q.idx == RTR_IDX_NONE)
    |=> $stable({q.coarse, q.fine, q.mon_en, q.conv, q.offset, q.slope, q.thr,
      q.limit_en}))
    else $error("configuration changed without a mapped write");

  unmapped_read_a: assert property (
    (q.bus == RTR_BUS_READ && q.idx == RTR_IDX_NONE) |=> hrdata == '0)
    else $error("unmapped read returned nonzero");

  slope_read_a: assert property (
    (q.bus == RTR_BUS_READ && q.idx == RTR_IDX_SLOPE)
    |=> hrdata == {24'h0, $past(q.slope)})
    else $error("slope read data wrong");

  coarse_status_a: assert property (
    (q.bus == RTR_BUS_READ && q.idx == RTR_IDX_STATUS)
    |=> hrdata[4:0] == $past(crystal_coarse_cap_code))
    else $error("status does not show applied coarse trim");

  fine_status_a: assert property (
    (q.bus == RTR_BUS_READ && q.idx == RTR_IDX_STATUS)
    |=> hrdata[10:8] == $past(cfg.fine_eighths))
    else $error("status does not show fine trim weight");

  conv_level_a: assert property (
    (converter_input_code == RTR_CONV_LEVEL)
    |-> conv_sel_level && !conv_sel_temp && !conv_sel_half_supply)
    else $error("level input not selected alone");

  conv_half_a: assert property (
    (converter_input_code == RTR_CONV_HALF_SUPPLY)
    |-> conv_sel_half_supply && !conv_sel_level && !conv_sel_temp)
    else $error("half supply input not selected alone");

  rate_pass_a: assert property (
    (q.limit_en && rate_dev_pos <= q.thr) |=> rate_accept)
    else $error("deviation within threshold rejected");

  write_cov_c: cover property (q.bus == RTR_BUS_WRITE && q.idx == RTR_IDX_COARSE);
  read_cov_c: cover property (q.bus == RTR_BUS_READ ##1 hreadyout);
  clamp_cov_c: cover property (q.coarse > RTR_COARSE_MAX);
  reject_cov_c: cover property (q.limit_en ##1 !rate_accept);
  unmapped_cov_c: cover property (q.bus == RTR_BUS_WRITE && q.idx == RTR_IDX_NONE);
endmodule : rtr_regs

// ### rtr_pkg.sv
// constants and types shared by the receiver trim and level register bank
package rtr_pkg;
  localparam int RTR_ADDR_W = 12;
  localparam int RTR_DATA_W = 32;
  localparam logic [7:0] RTR_IDX_COARSE = 8'h8C;
  localparam logic [7:0] RTR_IDX_FINE = 8'h8D;
  localparam logic [7:0] RTR_IDX_MONITOR = 8'h8E;
  localparam logic [7:0] RTR_IDX_CONVERTER = 8'h8F;
  localparam logic [7:0] RTR_IDX_OFFSET = 8'h90;
  localparam logic [7:0] RTR_IDX_SLOPE = 8'h91;
  localparam logic [7:0] RTR_IDX_POS_THR = 8'h92;
  localparam logic [7:0] RTR_IDX_CONTROL = 8'hA0;
  localparam logic [7:0] RTR_IDX_STATUS = 8'hA1;
  localparam logic [7:0] RTR_IDX_NONE = 8'hFF;
  localparam logic [4:0] RTR_RST_COARSE = 5'h10;
  localparam logic [3:0] RTR_RST_FINE = 4'h0;
  localparam logic RTR_RST_MON_EN = 1'b1;
  localparam logic [2:0] RTR_RST_CONVERTER = 3'h0;
  localparam logic [7:0] RTR_RST_OFFSET = 8'h80;
  localparam logic [7:0] RTR_RST_SLOPE = 8'h80;
  localparam logic [7:0] RTR_RST_POS_THR = 8'h1E;
  localparam logic RTR_RST_LIMIT_EN = 1'b0;
  localparam logic [4:0] RTR_COARSE_MAX = 5'h18;
  localparam int RTR_COARSE_W = 5;
  localparam int RTR_FINE_W = 4;
  localparam int RTR_CONV_W = 3;
  localparam int RTR_MON_EN_BIT = 0;
  localparam int RTR_LIMIT_EN_BIT = 0;
  localparam int RTR_STAT_COARSE_LSB = 0;
  localparam int RTR_STAT_FINE_LSB = 8;
  localparam int RTR_STAT_ACCEPT_BIT = 16;
  localparam int RTR_SLOPE_SHIFT = 7;
  localparam logic [2:0] RTR_CONV_LEVEL = 3'h0;
  localparam logic [2:0] RTR_CONV_TEMP = 3'h1;
  localparam logic [2:0] RTR_CONV_HALF_SUPPLY = 3'h2;
  localparam logic [1:0] RTR_HTRANS_NONSEQ = 2'h2;
  typedef enum logic [1:0] {
    RTR_BUS_IDLE = 2'b00,
    RTR_BUS_WRITE = 2'b01,
    RTR_BUS_READ = 2'b10
  } rtr_bus_t;
endpackage : rtr_pkg

// ### rtr_cfg_if.sv
// configuration and result signals between the register bank and its helpers
`timescale 1ns/1ns
interface rtr_cfg_if;
  logic [4:0] coarse_code;
  logic [3:0] fine_bits;
  logic [4:0] coarse_applied;
  logic [2:0] fine_eighths;
  logic [7:0] level_in;
  logic [7:0] slope;
  logic [7:0] offset;
  logic [8:0] offset_value;
  logic [10:0] level_comp;
  modport regs (output coarse_code, output fine_bits, output level_in, output slope,
    output offset, input coarse_applied, input fine_eighths, input offset_value,
    input level_comp);
  modport trim (input coarse_code, input fine_bits, output coarse_applied,
    output fine_eighths);
  modport comp (input level_in, input slope, input offset, output offset_value,
    output level_comp);
endinterface : rtr_cfg_if

// ### rtr_trim_decode.sv
// crystal trim decode: coarse code saturation and fine capacitor weights
`timescale 1ns/1ns
module rtr_trim_decode
  import rtr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  rtr_cfg_if.trim cfg
);
  typedef struct packed {
    logic [4:0] coarse_applied;
    logic [2:0] fine_eighths;
  } rtr_trim_t;
  rtr_trim_t q;
  rtr_trim_t next_q;

  always_comb begin
    next_q = q;
    // one pF per step, codes past the top clamp to it
    if (cfg.coarse_code > RTR_COARSE_MAX) begin
      next_q.coarse_applied = RTR_COARSE_MAX;
    end else begin
      next_q.coarse_applied = cfg.coarse_code;
    end
    // 500/250/125 fF switches, counted in eighths of a pF
    next_q.fine_eighths = cfg.fine_bits[3:1];
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      q <= '{coarse_applied: RTR_RST_COARSE, fine_eighths: RTR_RST_FINE[3:1]};
    end else begin
      q <= next_q;
    end
  end

  assign cfg.coarse_applied = q.coarse_applied;
  assign cfg.fine_eighths = q.fine_eighths;
endmodule : rtr_trim_decode

// ### rtr_level_comp.sv
// signal level compensation: slope in steps of 1/128, then offset in steps of two
`timescale 1ns/1ns
module rtr_level_comp
  import rtr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  rtr_cfg_if.comp cfg
);
  typedef struct packed {
    logic [8:0] offset_value;
    logic [10:0] level_comp;
  } rtr_comp_t;
  rtr_comp_t q;
  rtr_comp_t next_q;
  logic [15:0] product;
  logic [8:0] scaled;
  logic [8:0] offset_now;

  always_comb begin
    next_q = q;
    product = cfg.level_in * cfg.slope;
    scaled = product[15:RTR_SLOPE_SHIFT];
    // flipping the top bit and appending a zero turns code 00h..FFh into -256..254
    offset_now = {~cfg.offset[7], cfg.offset[6:0], 1'b0};
    next_q.offset_value = offset_now;
    next_q.level_comp = 11'({2'b00, scaled} + {{2{offset_now[8]}}, offset_now});
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign cfg.offset_value = q.offset_value;
  assign cfg.level_comp = q.level_comp;
endmodule : rtr_level_comp

// ### tb_rtr_regs.sv
// self-checking bench for the receiver trim and level register bank
`timescale 1ns/1ns
module tb_rtr_regs
  import rtr_pkg::*;
;
  logic ref_clk, reset, hsel, hwrite, hreadyout, hresp, rate_accept;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize, converter_input_code;
  logic [31:0] hwdata, hrdata, r;
  logic [7:0] level_sample, rate_dev_pos;
  logic [4:0] crystal_coarse_cap_code;
  logic f500, f250, f125, flsb, level_monitor_buffer_enable, cs_lvl, cs_tmp, cs_half;
  logic [8:0] level_offset_value;
  logic [10:0] level_compensated;
  int n_errors, checks;

  rtr_regs rtr_regs_inst (.ref_clk(ref_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .level_sample(level_sample),
    .rate_dev_pos(rate_dev_pos), .crystal_coarse_cap_code(crystal_coarse_cap_code),
    .crystal_fine_cap_500ff(f500), .crystal_fine_cap_250ff(f250),
    .crystal_fine_cap_125ff(f125), .crystal_fine_cap_lsb(flsb),
    .level_monitor_buffer_enable(level_monitor_buffer_enable),
    .converter_input_code(converter_input_code), .conv_sel_level(cs_lvl),
    .conv_sel_temp(cs_tmp), .conv_sel_half_supply(cs_half),
    .level_offset_value(level_offset_value), .level_compensated(level_compensated),
    .rate_accept(rate_accept));

  always #10 ref_clk = ~ref_clk;

  function automatic logic [11:0] ba(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction : ba

  task automatic end_sim;
    if (n_errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // waits for hready high at an edge; a stuck bus ends the run
  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      n_errors++;
      end_sim();
    end
  endtask : wait_ready

  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= RTR_HTRANS_NONSEQ;
    hwrite <= w;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    r = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask : xfer

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask : wr

  task automatic rd(input logic [11:0] a);
    xfer(a, 1'b0, 32'h0);
  endtask : rd

  // derived outputs lag their register by at most one cycle
  task automatic settle;
    repeat (3) @(posedge ref_clk);
  endtask : settle

  logic [7:0] ridx [8] = '{RTR_IDX_COARSE, RTR_IDX_FINE, RTR_IDX_MONITOR, RTR_IDX_CONVERTER,
    RTR_IDX_OFFSET, RTR_IDX_SLOPE, RTR_IDX_POS_THR, RTR_IDX_CONTROL};
  logic [31:0] rval [8] = '{32'h10, 32'h0, 32'h1, 32'h0, 32'h80, 32'h80, 32'h1E, 32'h0};
  logic [31:0] ctab [7] = '{32'h0, 32'h1, 32'h17, 32'h18, 32'h19, 32'h1F, 32'hFF};
  logic [31:0] ftab [5] = '{32'h8, 32'h4, 32'h2, 32'h1, 32'hFF};
  // offset, slope, level sample triples for the compensation path
  logic [7:0] otab [4] = '{8'h00, 8'hFF, 8'h80, 8'h81};
  logic [7:0] stab [4] = '{8'h80, 8'hFF, 8'h00, 8'h40};
  logic [7:0] ltab [4] = '{8'h64, 8'hFF, 8'hC8, 8'h03};

  initial begin
    int e;
    logic [4:0] c;
    ref_clk = 1'b0;
    reset = 1'b1;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    level_sample = 8'h5A;
    rate_dev_pos = 8'hFF;
    n_errors = 0;
    checks = 0;
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    chk(crystal_coarse_cap_code, 32'd16);
    chk({level_monitor_buffer_enable, cs_lvl, rate_accept}, 32'h7);
    for (int i = 0; i < 8; i++) begin
      rd(ba(ridx[i]));
      chk(r, rval[i]);
    end
    chk(level_compensated, 32'h5A);
    // coarse codes across the knee at 18h, unused bits set last
    foreach (ctab[i]) begin
      wr(ba(RTR_IDX_COARSE), ctab[i]);
      rd(ba(RTR_IDX_COARSE));
      chk(r, ctab[i] & 32'h1F);
      c = ctab[i][4:0];
      settle();
      chk(crystal_coarse_cap_code, (c > 5'h18) ? 32'h18 : {27'h0, c});
      rd(ba(RTR_IDX_STATUS));
      chk(r[4:0], (c > 5'h18) ? 32'h18 : {27'h0, c});
    end
    foreach (ftab[i]) begin
      wr(ba(RTR_IDX_FINE), ftab[i]);
      rd(ba(RTR_IDX_FINE));
      chk(r, ftab[i] & 32'hF);
      settle();
      chk({f500, f250, f125, flsb}, ftab[i] & 32'hF);
      rd(ba(RTR_IDX_STATUS));
      chk(r[10:8], {29'h0, ftab[i][3:1]});
    end
    wr(ba(RTR_IDX_MONITOR), 32'hFE);
    settle();
    chk(level_monitor_buffer_enable, 32'h0);
    wr(ba(RTR_IDX_MONITOR), 32'hFF);
    rd(ba(RTR_IDX_MONITOR));
    chk(r, 32'h1);
    chk(level_monitor_buffer_enable, 32'h1);
    for (int k = 0; k < 8; k++) begin
      wr(ba(RTR_IDX_CONVERTER), 32'hF8 | k);
      rd(ba(RTR_IDX_CONVERTER));
      chk(r, k);
      settle();
      chk(converter_input_code, k);
      chk({cs_half, cs_tmp, cs_lvl}, (k == 0) ? 1 : (k == 1) ? 2 : (k == 2) ? 4 : 0);
    end
    foreach (otab[i]) begin
      wr(ba(RTR_IDX_OFFSET), {24'h0, otab[i]});
      wr(ba(RTR_IDX_SLOPE), {24'h0, stab[i]});
      level_sample <= ltab[i];
      settle();
      e = 2 * otab[i] - 256;
      chk(level_offset_value, 32'(e) & 32'h1FF);
      e = e + ((ltab[i] * stab[i]) >> 7);
      chk(level_compensated, 32'(e) & 32'h7FF);
    end
    // threshold ignored while the check is off, equal deviation accepted
    settle();
    chk(rate_accept, 32'h1);
    wr(ba(RTR_IDX_CONTROL), 32'h1);
    settle();
    chk(rate_accept, 32'h0);
    rate_dev_pos <= 8'h1E;
    settle();
    chk(rate_accept, 32'h1);
    rate_dev_pos <= 8'h1F;
    wr(ba(RTR_IDX_POS_THR), 32'h1F);
    settle();
    chk(rate_accept, 32'h1);
    wr(ba(RTR_IDX_POS_THR), 32'h1E);
    settle();
    chk(rate_accept, 32'h0);
    // unmapped and misaligned places read zero and swallow writes
    wr(12'h3FC, 32'hFFFF_FFFF);
    rd(12'h3FC);
    chk(r, 32'h0);
    wr(ba(RTR_IDX_SLOPE) | 12'h1, 32'h11);
    rd(ba(RTR_IDX_SLOPE) | 12'h1);
    chk(r, 32'h0);
    rd(ba(RTR_IDX_SLOPE));
    chk(r, {24'h0, stab[3]});
    end_sim();
  end
endmodule : tb_rtr_regs
